// *** dotc_pkg.sv ***
// Purpose: shared constants for the discrete output 1 and trend control block
// Assumes: 250 MHz core clock, 32-bit register port, byte offsets
// Notes:   grade codes rise as quality falls, 0 is the best grade
package dotc_pkg;

   // clock and time base
   localparam int unsigned CLK_MHZ       = 250;
   localparam int unsigned PULSE_UNIT_MS = 1;
   localparam int unsigned MS_CYCLES     = PULSE_UNIT_MS * CLK_MHZ * 1000;

   // register byte offsets
   localparam logic [7:0] OFS_OUTPUT_CFG = 8'h00;
   localparam logic [7:0] OFS_PULSE      = 8'h04;
   localparam logic [7:0] OFS_TREND_CFG  = 8'h08;
   localparam logic [7:0] OFS_DPT_THR    = 8'h0C;
   localparam logic [7:0] OFS_QUALITY    = 8'h10;
   localparam logic [7:0] OFS_STATUS     = 8'h14;
   localparam logic [7:0] OFS_DPT_STATUS = 8'h18;

   // field positions
   localparam int unsigned POS_OUT_ON    = 0;
   localparam int unsigned POS_OUT_STATE = 3;
   localparam int unsigned POS_OUT_MODE  = 4;
   localparam int unsigned POS_TR_MODE   = 0;
   localparam int unsigned POS_TR_PERIOD = 8;
   localparam int unsigned POS_TR_NUMBER = 16;
   localparam int unsigned POS_Q_EN      = 0;
   localparam int unsigned POS_Q_THR     = 4;
   localparam int unsigned POS_ST_EVT    = 8;
   localparam int unsigned POS_ST_TRIG   = 16;

   // output on selections
   localparam logic [2:0] ON_MISMATCH_OR_NOREAD = 3'h0;
   localparam logic [2:0] ON_MATCH              = 3'h1;
   localparam logic [2:0] ON_MISMATCH           = 3'h2;
   localparam logic [2:0] ON_NOREAD             = 3'h3;
   localparam logic [2:0] ON_TREND              = 3'h4;
   localparam logic [2:0] ON_QUALITY            = 3'h5;
   localparam logic [2:0] ON_DIAG_WARNING       = 3'h6;
   localparam logic [2:0] ON_IN_READ_CYCLE      = 3'h7;

   // de-activation modes
   localparam logic [1:0] MODE_PULSE         = 2'h0;
   localparam logic [1:0] MODE_LATCH_OPPOSITE = 2'h2;
   localparam logic [1:0] MODE_LATCH_NEWCYCLE = 2'h3;

   // trend conditions
   localparam logic [1:0] TREND_MISMATCH = 2'h0;
   localparam logic [1:0] TREND_NOREAD   = 2'h1;
   localparam logic [1:0] TREND_DPT      = 2'h2;

   // reset values
   localparam logic [2:0]  RST_OUT_ON    = ON_MISMATCH_OR_NOREAD;
   localparam logic        RST_OUT_STATE = 1'h0;
   localparam logic [1:0]  RST_OUT_MODE  = MODE_PULSE;
   localparam logic [15:0] RST_PULSE     = 16'h01F4;
   localparam logic [1:0]  RST_TR_MODE   = TREND_NOREAD;
   localparam logic [7:0]  RST_TR_PERIOD = 8'h00;
   localparam logic [7:0]  RST_TR_NUMBER = 8'h00;
   localparam logic [15:0] RST_DPT_THR   = 16'h0000;
   localparam logic [3:0]  RST_Q_EN      = 4'h0;
   localparam logic [7:0]  RST_Q_THR     = 8'hAA;

endpackage : dotc_pkg

// *** dotc_pulse.sv ***
// Purpose: timed pulse of the programmed width in millisecond units
// Assumes: start and abort are single-cycle requests on the core clock
// Notes:   busy rises the cycle after start and lasts width*ms_cycles cycles
`timescale 1ns/1ps
module dotc_pulse #(
   parameter int unsigned MS_CYCLES = dotc_pkg::MS_CYCLES
) (
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   input  wire logic        i_ce,
   input  wire logic        i_start,
   input  wire logic        i_abort,
   input  wire logic [15:0] i_width,
   output logic             o_busy
);

   logic [31:0] ms_cnt_reg;
   logic [15:0] left_reg;

   always_ff @(posedge i_clock)
   begin
      if (i_rst || (i_ce && i_abort))
      begin
         ms_cnt_reg <= 32'h0;
         left_reg   <= 16'h0;
         o_busy     <= 1'b0;
      end
      else if (i_ce)
      begin
         if (i_start)
         begin
            // retrigger restarts the full width
            ms_cnt_reg <= 32'h0;
            left_reg   <= i_width;
            o_busy     <= (i_width != 16'h0);
         end
         else if (o_busy)
         begin
            if (ms_cnt_reg == MS_CYCLES - 1)
            begin
               ms_cnt_reg <= 32'h0;
               left_reg   <= left_reg - 16'h1;
               o_busy     <= (left_reg != 16'h1);
            end
            else
            begin
               ms_cnt_reg <= ms_cnt_reg + 32'h1;
            end
         end
      end
   end

endmodule : dotc_pulse

// *** dotc_trend.sv ***
// Purpose: trend counting of read-cycle outcomes over a trigger window
// Assumes: event pulses come from engines on the same clock
// Notes:   a window of 0 triggers never closes, counters saturate instead
`timescale 1ns/1ps
module dotc_trend (
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   input  wire logic        i_ce,
   input  wire logic [1:0]  i_mode,
   input  wire logic [7:0]  i_period,
   input  wire logic [7:0]  i_number,
   input  wire logic [15:0] i_dpt_thr,
   input  wire logic        i_dpt_en,
   input  wire logic        i_cycle_start,
   input  wire logic        i_cycle_end,
   input  wire logic        i_no_read,
   input  wire logic        i_mismatch,
   input  wire logic        i_decode,
   output logic             o_hit,
   output logic             o_window_done,
   output logic [7:0]       o_event_count,
   output logic [7:0]       o_trig_count,
   output logic [15:0]      o_last_decodes
);

   logic        nr_seen_reg;
   logic        mm_seen_reg;
   logic [15:0] dec_cnt_reg;
   logic [15:0] dec_now;
   logic        dpt_active;
   logic        dpt_low;
   logic        event_now;
   logic [7:0]  evt_next;
   logic        window_end;

   always_comb
   begin
      dec_now    = (i_decode && dec_cnt_reg != 16'hFFFF) ? dec_cnt_reg + 16'h1 : dec_cnt_reg;
      dpt_active = (i_mode == dotc_pkg::TREND_DPT) && i_dpt_en;
      dpt_low    = dpt_active && (dec_now < i_dpt_thr);
      case (i_mode)
         dotc_pkg::TREND_MISMATCH: event_now = mm_seen_reg || i_mismatch;
         dotc_pkg::TREND_NOREAD:   event_now = nr_seen_reg || i_no_read;
         dotc_pkg::TREND_DPT:      event_now = dpt_low;
         default:                  event_now = 1'b0;
      endcase
      evt_next   = (event_now && o_event_count != 8'hFF) ? o_event_count + 8'h1 : o_event_count;
      window_end = (i_period != 8'h0) && (o_trig_count + 8'h1 == i_period);
   end

   // per read-cycle outcome capture
   always_ff @(posedge i_clock)
   begin
      if (i_rst || (i_ce && i_cycle_end))
      begin
         nr_seen_reg <= 1'b0;
         mm_seen_reg <= 1'b0;
         dec_cnt_reg <= 16'h0;
      end
      else if (i_ce && i_cycle_start)
      begin
         // an outcome in the start cycle belongs to the new cycle, so it is kept
         nr_seen_reg <= i_no_read;
         mm_seen_reg <= i_mismatch;
         dec_cnt_reg <= {15'h0, i_decode};
      end
      else if (i_ce)
      begin
         nr_seen_reg <= nr_seen_reg || i_no_read;
         mm_seen_reg <= mm_seen_reg || i_mismatch;
         dec_cnt_reg <= dec_now;
      end
   end

   // window counters and decision
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         o_event_count  <= 8'h0;
         o_trig_count   <= 8'h0;
         o_hit          <= 1'b0;
         o_window_done  <= 1'b0;
         o_last_decodes <= 16'h0;
      end
      else if (i_ce)
      begin
         o_hit         <= 1'b0;
         o_window_done <= 1'b0;
         if (i_cycle_end)
         begin
            o_last_decodes <= dec_now;
            // count reaching the threshold exactly, not passing it, fires once per window
            o_hit <= dpt_low || (i_number != 8'h0 && event_now && evt_next == i_number);
            if (window_end)
            begin
               o_event_count <= 8'h0;
               o_trig_count  <= 8'h0;
               o_window_done <= 1'b1;
            end
            else
            begin
               o_event_count <= evt_next;
               o_trig_count  <= (o_trig_count != 8'hFF) ? o_trig_count + 8'h1 : o_trig_count;
            end
         end
      end
   end

endmodule : dotc_trend

// *** dotc_top.sv ***
// Purpose: discrete output 1 control with pulse, latch, trend and quality drive
// Assumes: event inputs come from decode, match and grading logic on i_clock
// Notes:   registers sit on a plain strobe port, read data one cycle later
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps

module dotc_top #(
   parameter int unsigned MS_CYCLES = dotc_pkg::MS_CYCLES
) (
   input  wire logic        i_clock,
   input  wire logic        i_rst,
   input  wire logic        i_ce,
   input  wire logic [7:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic [31:0]      o_rdata,
   input  wire logic        i_cycle_start,
   input  wire logic        i_cycle_end,
   input  wire logic        i_good_read,
   input  wire logic        i_no_read,
   input  wire logic        i_match,
   input  wire logic        i_mismatch,
   input  wire logic        i_decode,
   input  wire logic        i_warning_active,
   input  wire logic        i_quality_valid,
   input  wire logic [7:0]  i_grades,
   output logic             o_output1,
   output logic             o_append_decode_count
);

   typedef enum logic [0:0] {
      ST_IDLE,
      ST_LATCH
   } dotc_state_e;

   // configuration registers
   logic [2:0]  out_on_reg;
   logic        out_state_reg;
   logic [1:0]  out_mode_reg;
   logic [15:0] pulse_width_reg;
   logic [1:0]  trend_mode_reg;
   logic [7:0]  trend_period_reg;
   logic [7:0]  trend_number_reg;
   logic [15:0] dpt_thr_reg;
   logic [3:0]  qual_en_reg;
   logic [7:0]  qual_thr_reg;
   logic        dpt_status_reg;

   // activation state
   dotc_state_e st_reg;
   dotc_state_e st_next;
   logic        active_next;
   logic        set_ev;
   logic        clr_ev;
   logic        pulse_start;
   logic        pulse_busy;
   logic [3:0]  qual_met;
   logic        qual_hit;
   logic        trend_hit;
   logic        window_done;
   logic [7:0]  event_count;
   logic [7:0]  trig_count;
   logic [15:0] last_decodes;
   logic [31:0] rdata_next;

   // worse grades carry larger codes, so a grade meets a threshold at or above it
   function automatic logic grade_met(input logic [1:0] grade, input logic [1:0] thr);
      grade_met = (grade >= thr);
   endfunction : grade_met

   function automatic logic hit_write(input logic [7:0] addr, input logic [7:0] ofs, input logic wr);
      hit_write = wr && (addr == ofs);
   endfunction : hit_write

   // register writes
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         out_on_reg       <= dotc_pkg::RST_OUT_ON;
         out_state_reg    <= dotc_pkg::RST_OUT_STATE;
         out_mode_reg     <= dotc_pkg::RST_OUT_MODE;
         pulse_width_reg  <= dotc_pkg::RST_PULSE;
         trend_mode_reg   <= dotc_pkg::RST_TR_MODE;
         trend_period_reg <= dotc_pkg::RST_TR_PERIOD;
         trend_number_reg <= dotc_pkg::RST_TR_NUMBER;
         dpt_thr_reg      <= dotc_pkg::RST_DPT_THR;
         qual_en_reg      <= dotc_pkg::RST_Q_EN;
         qual_thr_reg     <= dotc_pkg::RST_Q_THR;
         dpt_status_reg   <= 1'b0;
      end
      else if (i_ce)
      begin
         if (hit_write(i_addr, dotc_pkg::OFS_OUTPUT_CFG, i_wr))
         begin
            out_on_reg    <= i_wdata[dotc_pkg::POS_OUT_ON +: 3];
            out_state_reg <= i_wdata[dotc_pkg::POS_OUT_STATE];
            // code 1 is not a mode, so the old mode is kept
            if (i_wdata[dotc_pkg::POS_OUT_MODE +: 2] != 2'h1)
            begin
               out_mode_reg <= i_wdata[dotc_pkg::POS_OUT_MODE +: 2];
            end
         end
         if (hit_write(i_addr, dotc_pkg::OFS_PULSE, i_wr))
         begin
            pulse_width_reg <= i_wdata[15:0];
         end
         if (hit_write(i_addr, dotc_pkg::OFS_TREND_CFG, i_wr))
         begin
            if (i_wdata[dotc_pkg::POS_TR_MODE +: 2] != 2'h3)
            begin
               trend_mode_reg <= i_wdata[dotc_pkg::POS_TR_MODE +: 2];
            end
            trend_period_reg <= i_wdata[dotc_pkg::POS_TR_PERIOD +: 8];
            trend_number_reg <= i_wdata[dotc_pkg::POS_TR_NUMBER +: 8];
         end
         if (hit_write(i_addr, dotc_pkg::OFS_DPT_THR, i_wr))
         begin
            dpt_thr_reg <= i_wdata[15:0];
         end
         if (hit_write(i_addr, dotc_pkg::OFS_QUALITY, i_wr))
         begin
            qual_en_reg  <= i_wdata[dotc_pkg::POS_Q_EN +: 4];
            qual_thr_reg <= i_wdata[dotc_pkg::POS_Q_THR +: 8];
         end
         if (hit_write(i_addr, dotc_pkg::OFS_DPT_STATUS, i_wr))
         begin
            dpt_status_reg <= i_wdata[0];
         end
      end
   end

   // quality metrics: contrast, print growth, axial non-uniformity, unused error correction
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++)
      begin : g_qual
         assign qual_met[gi] = qual_en_reg[gi] && grade_met(i_grades[2*gi +: 2], qual_thr_reg[2*gi +: 2]);
      end
   endgenerate
   assign qual_hit = i_quality_valid && (qual_met != 4'h0);

   dotc_trend u_trend (
      .i_clock        (i_clock),
      .i_rst          (i_rst),
      .i_ce           (i_ce),
      .i_mode         (trend_mode_reg),
      .i_period       (trend_period_reg),
      .i_number       (trend_number_reg),
      .i_dpt_thr      (dpt_thr_reg),
      .i_dpt_en       (dpt_status_reg),
      .i_cycle_start  (i_cycle_start),
      .i_cycle_end    (i_cycle_end),
      .i_no_read      (i_no_read),
      .i_mismatch     (i_mismatch),
      .i_decode       (i_decode),
      .o_hit          (trend_hit),
      .o_window_done  (window_done),
      .o_event_count  (event_count),
      .o_trig_count   (trig_count),
      .o_last_decodes (last_decodes)
   );

   // activation condition and its opposite
   always_comb
   begin
      set_ev = 1'b0;
      clr_ev = 1'b0;
      case (out_on_reg)
         dotc_pkg::ON_MISMATCH_OR_NOREAD:
         begin
            set_ev = i_mismatch || i_no_read;
            clr_ev = i_match;
         end
         dotc_pkg::ON_MATCH:
         begin
            set_ev = i_match;
            clr_ev = i_mismatch || i_no_read;
         end
         dotc_pkg::ON_MISMATCH:
         begin
            set_ev = i_mismatch;
            clr_ev = i_match;
         end
         dotc_pkg::ON_NOREAD:
         begin
            set_ev = i_no_read;
            clr_ev = i_good_read;
         end
         dotc_pkg::ON_TREND:
         begin
            set_ev = trend_hit;
            clr_ev = window_done && !trend_hit;
         end
         dotc_pkg::ON_QUALITY:
         begin
            set_ev = qual_hit;
            clr_ev = i_quality_valid && !qual_hit;
         end
         dotc_pkg::ON_IN_READ_CYCLE:
         begin
            set_ev = i_cycle_start;
            clr_ev = i_cycle_end;
         end
         default:
         begin
            // diagnostic warning drives the output through the warning path only
            set_ev = 1'b0;
            clr_ev = 1'b0;
         end
      endcase
   end

   // latch state machine; a set in the same cycle as its clear wins
   always_comb
   begin
      st_next     = st_reg;
      pulse_start = 1'b0;
      if (i_warning_active)
      begin
         st_next = ST_IDLE;
      end
      else
      begin
         case (st_reg)
            ST_IDLE:
            begin
               if (set_ev && out_mode_reg == dotc_pkg::MODE_PULSE)
               begin
                  pulse_start = 1'b1;
               end
               else if (set_ev)
               begin
                  st_next = ST_LATCH;
               end
            end
            ST_LATCH:
            begin
               if (out_mode_reg == dotc_pkg::MODE_PULSE)
               begin
                  st_next = ST_IDLE;
               end
               else if (set_ev)
               begin
                  st_next = ST_LATCH;
               end
               else if (out_mode_reg == dotc_pkg::MODE_LATCH_OPPOSITE && clr_ev)
               begin
                  st_next = ST_IDLE;
               end
               else if (out_mode_reg == dotc_pkg::MODE_LATCH_NEWCYCLE && i_cycle_start)
               begin
                  st_next = ST_IDLE;
               end
            end
            default:
            begin
               st_next = ST_IDLE;
            end
         endcase
         if (st_reg == ST_IDLE && set_ev && out_mode_reg == dotc_pkg::MODE_PULSE)
         begin
            st_next = ST_IDLE;
         end
      end
      // a warning assigned to this output drives it and masks everything else
      active_next = i_warning_active || (st_next == ST_LATCH) || pulse_busy;
   end

   dotc_pulse #(
      .MS_CYCLES (MS_CYCLES)
   ) u_pulse (
      .i_clock (i_clock),
      .i_rst   (i_rst),
      .i_ce    (i_ce),
      .i_start (pulse_start),
      .i_abort (i_warning_active),
      .i_width (pulse_width_reg),
      .o_busy  (pulse_busy)
   );

   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         st_reg <= ST_IDLE;
      end
      else if (i_ce)
      begin
         st_reg <= st_next;
      end
   end

   // electrical level: normally closed inverts the active state
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         o_output1             <= dotc_pkg::RST_OUT_STATE;
         o_append_decode_count <= 1'b0;
      end
      else if (i_ce)
      begin
         o_output1             <= active_next ^ out_state_reg;
         o_append_decode_count <= dpt_status_reg;
      end
   end

   // read mux, unmapped offsets read as zero
   always_comb
   begin
      rdata_next = 32'h0;
      case (i_addr)
         dotc_pkg::OFS_OUTPUT_CFG:
         begin
            rdata_next[dotc_pkg::POS_OUT_ON +: 3]   = out_on_reg;
            rdata_next[dotc_pkg::POS_OUT_STATE]     = out_state_reg;
            rdata_next[dotc_pkg::POS_OUT_MODE +: 2] = out_mode_reg;
         end
         dotc_pkg::OFS_PULSE:      rdata_next[15:0] = pulse_width_reg;
         dotc_pkg::OFS_TREND_CFG:
         begin
            rdata_next[dotc_pkg::POS_TR_MODE +: 2]   = trend_mode_reg;
            rdata_next[dotc_pkg::POS_TR_PERIOD +: 8] = trend_period_reg;
            rdata_next[dotc_pkg::POS_TR_NUMBER +: 8] = trend_number_reg;
         end
         dotc_pkg::OFS_DPT_THR:    rdata_next[15:0] = dpt_thr_reg;
         dotc_pkg::OFS_QUALITY:
         begin
            rdata_next[dotc_pkg::POS_Q_EN +: 4]  = qual_en_reg;
            rdata_next[dotc_pkg::POS_Q_THR +: 8] = qual_thr_reg;
         end
         dotc_pkg::OFS_STATUS:
         begin
            rdata_next[0]                         = o_output1 ^ out_state_reg;
            rdata_next[1]                         = (st_reg == ST_LATCH);
            rdata_next[2]                         = pulse_busy;
            rdata_next[dotc_pkg::POS_ST_EVT +: 8]  = event_count;
            rdata_next[dotc_pkg::POS_ST_TRIG +: 8] = trig_count;
         end
         dotc_pkg::OFS_DPT_STATUS:
         begin
            rdata_next[0]     = dpt_status_reg;
            rdata_next[31:16] = last_decodes;
         end
         default:                  rdata_next = 32'h0;
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         o_rdata <= 32'h0;
      end
      else if (i_ce)
      begin
         o_rdata <= i_rd ? rdata_next : 32'h0;
      end
   end

endmodule : dotc_top

// *** dotc_properties.sv ***
// Purpose: port checks for output 1 control
// Assumes: bound to dotc_top
// Notes:   shadows output config to know the active level
`timescale 1ns/1ps
module dotc_properties (
   input wire logic        i_clock,
   input wire logic        i_rst,
   input wire logic        i_ce,
   input wire logic [7:0]  i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic        i_cycle_start,
   input wire logic        i_good_read,
   input wire logic        i_no_read,
   input wire logic        i_warning_active,
   input wire logic        o_output1,
   input wire logic        o_append_decode_count
);
   logic [5:0] cfg_reg;
   logic       pw_reg;
   logic       act;
   logic       lat2;
   assign act  = o_output1 ^ cfg_reg[3];
   assign lat2 = cfg_reg[5:4] == 2'h2 && cfg_reg[2:0] == 3'h3;
   // a write of mode code 1 keeps the old mode, the other fields still land
   always_ff @(posedge i_clock)
   begin
      if (i_rst)
      begin
         cfg_reg <= 6'h00;
         pw_reg  <= 1'b1;
      end
      else if (i_ce && i_wr && i_addr == 8'h00)
      begin
         cfg_reg[3:0] <= i_wdata[3:0];
         if (i_wdata[5:4] != 2'h1)
         begin
            cfg_reg[5:4] <= i_wdata[5:4];
         end
      end
      else if (i_ce && i_wr && i_addr == 8'h04)
      begin
         pw_reg <= |i_wdata[15:0];
      end
   end
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   sequence s_arm;
      cfg_reg[5:4] == 2'h0 && cfg_reg[2:0] == 3'h3 && pw_reg && i_ce && i_no_read && !i_warning_active;
   endsequence
   sequence s_busy;
      1'b1 ##1 act;
   endsequence
   a_reset_quiet: assert property (disable iff (1'b0) i_rst |=> !o_output1 && o_rdata == 32'h0)
      else $error("outputs not quiet after reset");
   a_rdata_once: assert property (i_ce && !i_rd |=> o_rdata == 32'h0)
      else $error("read data outside its cycle");
   a_pulse_start: assert property (s_arm |=> s_busy)
      else $error("pulse did not start");
   a_latch_set: assert property (lat2 && i_ce && i_no_read |=> act)
      else $error("latch not set by no-read");
   a_latch_clear: assert property (lat2 && i_ce && i_good_read && !i_no_read && !i_warning_active |=> !act)
      else $error("latch not released by good read");
   a_newcycle_clear: assert property (cfg_reg[5:4] == 2'h3 && cfg_reg[2:0] == 3'h3 && i_ce && i_cycle_start
      && !i_no_read && !i_warning_active |=> !act)
      else $error("latch not released at cycle start");
   a_warn_drives: assert property (i_ce && i_warning_active |=> act)
      else $error("warning did not own the output");
   a_append_src: assert property ($changed(o_append_decode_count) |-> $past(i_ce && i_wr && i_addr == 8'h18, 2))
      else $error("append flag moved without a write");
endmodule : dotc_properties
bind dotc_top dotc_properties i_dotc_properties (.*);

// *** dotc_plc_model.sv ***
// Purpose: plc input timing how long output 1 stays active
// Assumes: polarity given by the bench
// Notes:   i_hold drops a reading while polarity changes
`timescale 1ns/1ps
module dotc_plc_model (
   input  wire logic   i_clock,
   input  wire logic   i_hold,
   input  wire logic   i_pol,
   input  wire logic   i_level,
   output logic        o_done,
   output logic [15:0] o_width
);
   logic [15:0] cnt_reg;
   always_ff @(posedge i_clock)
   begin
      o_done <= 1'b0;
      if (i_hold)
         cnt_reg <= 16'h0000;
      else if (i_level ^ i_pol)
         cnt_reg <= cnt_reg + 16'h0001;
      else if (cnt_reg != 16'h0000)
      begin
         o_done  <= 1'b1;
         o_width <= cnt_reg;
         cnt_reg <= 16'h0000;
      end
   end
endmodule : dotc_plc_model

// *** dotc_top_tb_top.sv ***
// Purpose: self-checking bench for dotc_top
// Assumes: one ms scaled to 4 cycles
// Notes:   reads and pulse widths checked from two queues
`timescale 1ns/1ps
module dotc_top_tb_top;
   localparam int unsigned MSC = 4;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        rd_q = 1'b0;
   logic [7:0]  ev = 8'h00;
   logic        warn = 1'b0;
   logic        pol = 1'b0;
   logic        hold = 1'b1;
   logic [7:0]  grades = 8'h00;
   logic [31:0] rdata;
   logic        out1;
   logic        plc_done;
   logic [15:0] plc_w;
   logic [31:0] exp_rd[$];
   logic [15:0] exp_w[$];
   int          err_total = 0;
   int          n_compared = 0;
   int          seed = 32'hFC585381;
   logic [31:0] v;
   logic [31:0] rv[8] = '{32'h0, 32'h1F4, 32'h1, 32'h0, 32'hAA0, 32'h0, 32'h0, 32'h0};
   dotc_top #(.MS_CYCLES(MSC)) i_dotc_top (.i_clock(clk), .i_rst(rst), .i_ce(1'b1), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_cycle_start(ev[7]), .i_cycle_end(ev[6]),
      .i_good_read(ev[5]), .i_no_read(ev[4]), .i_match(ev[3]), .i_mismatch(ev[2]), .i_decode(ev[1]),
      .i_warning_active(warn), .i_quality_valid(ev[0]), .i_grades(grades), .o_output1(out1),
      .o_append_decode_count());
   dotc_plc_model i_dotc_plc_model (.i_clock(clk), .i_hold(hold), .i_pol(pol), .i_level(out1),
      .o_done(plc_done), .o_width(plc_w));
   initial
   begin
      forever #2 clk = ~clk;
   end
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : print_verdict
   task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD %0t read exp %h got %h", $time, e, g);
      end
   endtask : cmp_rd
   task automatic cmp_w(input logic [15:0] e, input logic [15:0] g);
      n_compared++;
      if (g !== e)
      begin
         err_total++;
         $display("BAD %0t width exp %h got %h", $time, e, g);
      end
   endtask : cmp_w
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      rd <= 1'b0;
      @(posedge clk);
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
      exp_rd.push_back(e);
      addr <= a;
      rd <= 1'b1;
      wr <= 1'b0;
      @(posedge clk);
   endtask : rd_reg
   task automatic idle(input int n);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (n) @(posedge clk);
   endtask : idle
   task automatic pul(input logic [7:0] p);
      ev <= p;
      idle(1);
      ev <= 8'h00;
      @(posedge clk);
   endtask : pul
   task automatic cyc(input logic [2:0] f);
      pul(8'h80);
      pul({3'h0, f[2], 1'b0, f[1:0], 1'b0});
      pul(8'h40);
   endtask : cyc
   // the far side times widths, so results arrive late
   always @(posedge clk)
   begin
      if (rd_q)
         cmp_rd(exp_rd.pop_front(), rdata);
      if (plc_done === 1'b1)
         cmp_w(exp_w.pop_front(), plc_w);
      rd_q <= rd;
   end
   initial
   begin
      #(4 * 20000);
      err_total++;
      print_verdict();
   end
   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      hold <= 1'b0;
      for (int i = 0; i < 8; i++)
         rd_reg(8'(i * 4), rv[i]);
      wr_reg(8'h00, 32'h10);
      rd_reg(8'h00, 32'h0);
      v = $random(seed);
      wr_reg(8'h0C, v);
      rd_reg(8'h0C, {16'h0, v[15:0]});
      wr_reg(8'h04, 32'h1);
      wr_reg(8'h00, 32'h23);
      pul(8'h10);
      exp_w.push_back(16'h5);
      idle(3);
      pul(8'h20);
      wr_reg(8'h00, 32'h33);
      pul(8'h10);
      exp_w.push_back(16'h3);
      idle(1);
      pul(8'h80);
      wr_reg(8'h00, 32'h23);
      warn <= 1'b1;
      pul(8'h10);
      exp_w.push_back(16'h3);
      idle(1);
      warn <= 1'b0;
      wr_reg(8'h00, 32'h04);
      for (int m = 0; m < 2; m++)
      begin
         wr_reg(8'h08, 32'h0002_0300 | 32'(m));
         exp_w.push_back(16'(MSC));
         for (int c = 0; c < 3; c++)
            cyc((c == 1) ? 3'h0 : ((m == 1) ? 3'h4 : 3'h2));
      end
      wr_reg(8'h18, 32'h1);
      wr_reg(8'h0C, 32'h3);
      wr_reg(8'h08, 32'h2);
      exp_w.push_back(16'(MSC));
      cyc(3'h1);
      // let the decode pulse finish so a quality hit cannot retrigger it
      idle(6);
      rd_reg(8'h18, 32'h0001_0001);
      wr_reg(8'h00, 32'h05);
      for (int i = 0; i < 8; i++)
      begin
         wr_reg(8'h10, 32'hAA0 | (32'h1 << (i % 4)));
         grades <= 8'($random(seed));
         pul(8'h01);
         if (grades[(i % 4) * 2 +: 2] >= 2'h2)
            exp_w.push_back(16'(MSC));
         idle(8);
      end
      hold <= 1'b1;
      wr_reg(8'h00, 32'h0B);
      wr_reg(8'h04, 32'h2);
      pol <= 1'b1;
      idle(4);
      hold <= 1'b0;
      pul(8'h10);
      exp_w.push_back(16'(2 * MSC));
      for (int k = 0; k < 300 && exp_w.size() > 0; k++)
         @(posedge clk);
      if (exp_w.size() + exp_rd.size() != 0)
         err_total++;
      print_verdict();
   end
endmodule : dotc_top_tb_top
